// file: mcc_unit.sv
/*
  mcc_unit: machine check exception and checkstop entry for the core.
  assumes: one clock aclk, synchronous active low reset, an axi4-lite
  master, core-side inputs synchronous to aclk.
*/
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`include "mcc_cfg.svh"

module mcc_unit (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic bus_error_ack,
    input wire logic hard_reset_pending,
    input wire logic [31:0] insn_addr,
    input wire logic insn_exc_req,
    input wire logic context_sync,
    input wire logic lost_pending_exc,
    input wire logic data_bus_req,
    output logic insn_exc_take,
    output logic fetch_redirect,
    output logic [31:0] fetch_addr,
    output logic insn_suspend,
    output logic latch_freeze,
    output logic checkstop_out,
    output logic data_bus_oe,
    output logic mc_imprecise
);

    ////////////////////////////////////////////////////////////////////
    // declarations
    mcc_pkg::mcc_state_type state_ff;
    mcc_pkg::mcc_state_type nxt_state;
    logic [31:0] msw_ff, hw0_ff, sra_ff, sms_ff, ctrl_ff, fetch_addr_ff;
    logic taken_ff, imprec_ff, bea_dly_ff;
    // bus side strobes and decode
    logic wr_en, wr_err, rd_en, rd_err, wr_msw, wr_hw0, wr_stat, wr_ctrl;
    logic [31:0] rd_data, wmask, stat_word, msw_taken, sms_next, vec_base;
    // decision terms
    logic stopped, mc_event, take, stop, single_bus, recov;

    ////////////////////////////////////////////////////////////////////
    // bus front end
    mcc_axil_slave u_slave (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .wr_en(wr_en),
        .wr_err(wr_err),
        .rd_en(rd_en),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    // byte lanes into a bit mask
    assign wmask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};

    // write decode, read-only offsets accept and ignore
    always_comb begin
        wr_msw = 1'b0;
        wr_hw0 = 1'b0;
        wr_stat = 1'b0;
        wr_ctrl = 1'b0;
        wr_err = 1'b0;
        if (awaddr == `MCC_OFS_MSW) begin
            wr_msw = wr_en;
        end else if (awaddr == `MCC_OFS_HW0) begin
            wr_hw0 = wr_en;
        end else if (awaddr == `MCC_OFS_STAT) begin
            wr_stat = wr_en;
        end else if (awaddr == `MCC_OFS_CTRL) begin
            wr_ctrl = wr_en;
        end else if (awaddr == `MCC_OFS_SRA || awaddr == `MCC_OFS_SMS) begin
            wr_err = 1'b0;
        end else begin
            wr_err = 1'b1;
        end
    end

    // read decode, unmapped offsets answer slverr
    always_comb begin
        rd_data = 32'h0;
        rd_err = 1'b0;
        if (araddr == `MCC_OFS_MSW) begin
            rd_data = msw_ff;
        end else if (araddr == `MCC_OFS_HW0) begin
            rd_data = hw0_ff;
        end else if (araddr == `MCC_OFS_SRA) begin
            rd_data = sra_ff;
        end else if (araddr == `MCC_OFS_SMS) begin
            rd_data = sms_ff;
        end else if (araddr == `MCC_OFS_STAT) begin
            rd_data = stat_word;
        end else if (araddr == `MCC_OFS_CTRL) begin
            rd_data = ctrl_ff;
        end else begin
            rd_err = 1'b1;
        end
    end

    // status view of the block's own state
    always_comb begin
        stat_word = 32'h0;
        stat_word[`MCC_STAT_STOP] = stopped;
        stat_word[`MCC_STAT_TAKEN] = taken_ff;
        stat_word[`MCC_STAT_IMPREC] = imprec_ff;
        stat_word[`MCC_STAT_STATE +: 2] = state_ff;
    end

    ////////////////////////////////////////////////////////////////////
    // decision
    assign stopped = (state_ff == mcc_pkg::mcc_st_stop) ||
                     (state_ff == mcc_pkg::mcc_st_frozen);
    assign single_bus = ctrl_ff[`MCC_CTRL_SINGLE];

    assign mc_event = bus_error_ack & ~hard_reset_pending & ~stopped;

    mcc_decide u_decide (
        .mc_event(mc_event),
        .mc_enable(msw_ff[`MCC_MSW_MCEN]),
        .single_bus(single_bus),
        .gate_master(hw0_ff[`MCC_HW0_MASTER]),
        .gate_mfstop(hw0_ff[`MCC_HW0_MFSTOP]),
        .take_exc(take),
        .enter_stop(stop)
    );

    assign insn_exc_take = insn_exc_req & ~take & ~stop & ~stopped;

    assign recov = context_sync & ~lost_pending_exc;

    // state word on entry
    // the enable drops too, so a second check stops the core, except in the single-bus variant with either gate clear
    always_comb begin
        msw_taken = msw_ff & ~`MCC_MSW_CLR_MASK;
        msw_taken[`MCC_MSW_DEND] = msw_ff[`MCC_MSW_XEND];
    end

    always_comb begin
        sms_next = msw_ff;
        sms_next[`MCC_MSW_RECOV] = recov & msw_ff[`MCC_MSW_RECOV];
    end

    assign vec_base = msw_ff[`MCC_MSW_IP] ? `MCC_VEC_HIGH : 32'h0;

    ////////////////////////////////////////////////////////////////////
    // state machine
    // stop and frozen: no way out but reset
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            mcc_pkg::mcc_st_run, mcc_pkg::mcc_st_take: begin
                if (stop) begin
                    nxt_state = mcc_pkg::mcc_st_stop;
                end else if (take) begin
                    nxt_state = mcc_pkg::mcc_st_take;
                end else begin
                    nxt_state = mcc_pkg::mcc_st_run;
                end
            end
            mcc_pkg::mcc_st_stop: begin
                nxt_state = mcc_pkg::mcc_st_frozen;
            end
            default: begin
                nxt_state = mcc_pkg::mcc_st_frozen;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= mcc_pkg::mcc_st_run;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // suspend and freeze
    // freeze follows the detecting edge, one cycle inside the limit
    assign insn_suspend = stopped;
    assign latch_freeze = stopped;
    assign checkstop_out = stopped;

    assign fetch_redirect = (state_ff == mcc_pkg::mcc_st_take);
    assign fetch_addr = fetch_addr_ff;

    ////////////////////////////////////////////////////////////////////
    // architected registers, software writes ignored once stopped, except the status flag clears
    // state word update
    // hardware entry wins over a software write in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            msw_ff <= `MCC_MSW_RST;
        end else if (take) begin
            msw_ff <= msw_taken;
        end else if (wr_msw && !stopped) begin
            msw_ff <= (msw_ff & ~wmask) | (wdata & wmask);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hw0_ff <= `MCC_HW0_RST;
        end else if (wr_hw0 && !stopped) begin
            hw0_ff <= ((hw0_ff & ~wmask) | (wdata & wmask)) & `MCC_HW0_MASK;
        end
    end

    // variant select
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= `MCC_CTRL_RST;
        end else if (wr_ctrl && !stopped) begin
            ctrl_ff[`MCC_CTRL_SINGLE] <= wdata[`MCC_CTRL_SINGLE] | ~wstrb[0] & single_bus;
        end
    end

    // saved state and vector address
    // all captured on the taking edge, so they always describe one check
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sra_ff <= 32'h0;
            sms_ff <= 32'h0;
            fetch_addr_ff <= 32'h0;
        end else if (take) begin
            sra_ff <= insn_addr;
            sms_ff <= sms_next;
            fetch_addr_ff <= vec_base | `MCC_MC_VECTOR;
        end
    end

    // taken and imprecise flags
    // sticky flags: a set in the clearing cycle wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            taken_ff <= 1'b0;
            imprec_ff <= 1'b0;
        end else begin
            if (take) begin
                taken_ff <= 1'b1;
            end else if (wr_stat && wstrb[0] && wdata[`MCC_STAT_TAKEN]) begin
                taken_ff <= 1'b0;
            end
            if (take && single_bus) begin
                imprec_ff <= 1'b1;
            end else if (wr_stat && wstrb[0] && wdata[`MCC_STAT_IMPREC]) begin
                imprec_ff <= 1'b0;
            end
        end
    end

    assign mc_imprecise = imprec_ff;

    // data bus release
    // only the drive is dropped; captured data stays valid
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bea_dly_ff <= 1'b0;
        end else begin
            bea_dly_ff <= bus_error_ack;
        end
    end

    assign data_bus_oe = data_bus_req & ~bea_dly_ff;

    ////////////////////////////////////////////////////////////////////
    // assertions
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence stop_walk_s;
        (latch_freeze && state_ff == mcc_pkg::mcc_st_stop)
        ##1 (latch_freeze && state_ff == mcc_pkg::mcc_st_frozen);
    endsequence
    sequence taken_walk_s;
        fetch_redirect && !msw_ff[`MCC_MSW_MCEN] && fetch_addr[19:0] == 20'h00200;
    endsequence

    take_when_on_a: assert property (mc_event && msw_ff[`MCC_MSW_MCEN] |=> taken_walk_s)
        else $error("check with enable set not taken");
    stop_when_off_a: assert property (mc_event && !msw_ff[`MCC_MSW_MCEN]
        && !single_bus |=> state_ff == mcc_pkg::mcc_st_stop)
        else $error("check with enable clear did not stop");
    stop_holds_a: assert property (stopped |=> stopped && insn_suspend)
        else $error("checkstop left without reset");
    freeze_time_a: assert property (stop |=> stop_walk_s)
        else $error("freeze late after checkstop");
    hreset_block_a: assert property (bus_error_ack && hard_reset_pending
        && !stopped && state_ff == mcc_pkg::mcc_st_run |=> state_ff == mcc_pkg::mcc_st_run)
        else $error("check started under hard reset");
    insn_yield_a: assert property (mc_event |-> !insn_exc_take)
        else $error("instruction exception beat the check");
    ri_save_a: assert property (take && !recov |=> !sms_ff[`MCC_MSW_RECOV])
        else $error("unrecoverable check kept the recoverable bit");
    resume_addr_a: assert property (take |=> sra_ff == $past(insn_addr))
        else $error("resume address not saved");
    second_stop_a: assert property (fetch_redirect && !single_bus && bus_error_ack
        && !hard_reset_pending |=> stopped)
        else $error("second check did not stop");
    bus_release_a: assert property (bus_error_ack |=> !data_bus_oe)
        else $error("data bus still driven");
    gates_clear_a: assert property (mc_event && single_bus
        && !hw0_ff[`MCC_HW0_MASTER] |=> fetch_redirect)
        else $error("gated variant did not take check");
    endian_copy_a: assert property (take
        |=> msw_ff[`MCC_MSW_DEND] == $past(msw_ff[`MCC_MSW_XEND]))
        else $error("endian select not copied");

endmodule // mcc_unit

// file: mcc_cfg.svh
/*
  mcc_cfg.svh: offsets, field positions, reset values and timing counts
  for the machine check unit.
  assumes: included by bare name, 32-bit registers, 8-bit byte address.
*/
`ifndef MCC_CFG_SVH
`define MCC_CFG_SVH

// register byte offsets
`define MCC_OFS_MSW 8'h00
`define MCC_OFS_HW0 8'h04
`define MCC_OFS_SRA 8'h08
`define MCC_OFS_SMS 8'h0C
`define MCC_OFS_STAT 8'h10
`define MCC_OFS_CTRL 8'h14

// machine_state_word bits, numbered lsb = 0
`define MCC_MSW_XEND 16
`define MCC_MSW_MCEN 12
`define MCC_MSW_IP 6
`define MCC_MSW_RECOV 1
`define MCC_MSW_DEND 0
// power, interrupt, privilege, float, check enable, trace, translation and
// recoverable bits: cleared on a taken check
`define MCC_MSW_CLR_MASK 32'h0004FF32

// hw_implementation_reg0 gates: master at msb, machine_fault_stop_gate below
`define MCC_HW0_MASTER 31
`define MCC_HW0_MFSTOP 15
`define MCC_HW0_MASK 32'h80008000

// status and control fields
`define MCC_STAT_STOP 0
`define MCC_STAT_TAKEN 1
`define MCC_STAT_IMPREC 2
`define MCC_STAT_STATE 4
`define MCC_CTRL_SINGLE 0

// reset values
`define MCC_MSW_RST 32'h00000040
`define MCC_HW0_RST 32'h00000000
`define MCC_CTRL_RST 32'h00000000

// vector and timing
`define MCC_MC_VECTOR 32'h00000200
`define MCC_VEC_HIGH 32'hFFF00000
`define MCC_FREEZE_CYC 2
`define MCC_RESP_OKAY 2'h0
`define MCC_RESP_SLVERR 2'h2

`endif

// file: mcc_pkg.sv
/*
  mcc_pkg: types of the machine check unit.
  assumes: nothing is imported; users write mcc_pkg::name.
*/
package mcc_pkg;

    // gray coded along run -> take -> run and run -> stop -> frozen
    typedef enum logic [1:0] {
        mcc_st_run = 2'h0,
        mcc_st_take = 2'h1,
        mcc_st_stop = 2'h2,
        mcc_st_frozen = 2'h3
    } mcc_state_type;

endpackage

// file: mcc_decide.sv
/*
  mcc_decide: chooses between taking a machine check and checkstop.
  assumes: mc_event already qualified against hard reset.
*/
module mcc_decide (
    input wire logic mc_event,
    input wire logic mc_enable,
    input wire logic single_bus,
    input wire logic gate_master,
    input wire logic gate_mfstop,
    output logic take_exc,
    output logic enter_stop
);

    logic stop_allowed;

    // the two gates
    // both gates must be set before the single-bus variant may stop
    assign stop_allowed = single_bus ? (gate_master & gate_mfstop) : 1'b1;

    assign enter_stop = mc_event & ~mc_enable & stop_allowed;

    assign take_exc = mc_event & ~enter_stop;

endmodule // mcc_decide

// file: mcc_axil_slave.sv
/*
  mcc_axil_slave: axi4-lite slave front end, one write and one read at a time.
  assumes: register decode answers combinationally in the same cycle.
*/
`include "mcc_cfg.svh"

module mcc_axil_slave (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic wr_en,
    input wire logic wr_err,
    output logic rd_en,
    input wire logic [31:0] rd_data,
    input wire logic rd_err
);

    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [1:0] rresp_ff;
    logic [31:0] rdata_ff;

    // address and data taken together, so either order works
    assign awready = awvalid & wvalid & ~bvalid_ff;
    assign wready = awready;
    assign wr_en = awready;
    assign arready = ~rvalid_ff;
    assign rd_en = arvalid & ~rvalid_ff;

    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign rvalid = rvalid_ff;
    assign rresp = rresp_ff;
    assign rdata = rdata_ff;

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= `MCC_RESP_OKAY;
        end else if (wr_en) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_err ? `MCC_RESP_SLVERR : `MCC_RESP_OKAY;
        end else if (bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // read data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rresp_ff <= `MCC_RESP_OKAY;
            rdata_ff <= 32'h0;
        end else if (rd_en) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= rd_err ? `MCC_RESP_SLVERR : `MCC_RESP_OKAY;
            rdata_ff <= rd_data;
        end else if (rready) begin
            rvalid_ff <= 1'b0;
        end
    end

endmodule // mcc_axil_slave

// file: mcc_mem_ctrl_model.sv
/*
  mcc_mem_ctrl_model: memory controller that flags parity or ecc faults.
  assumes: aclk domain; a report comes lag+1 cycles after a fault is sampled and a new
  fault restarts the count; a fault held two cycles at lag 0 gives back-to-back reports.
*/
module mcc_mem_ctrl_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic fault,
    input wire logic [1:0] lag,
    output logic bus_error_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ack_ff;
    logic pend_ff;
    logic [1:0] cnt_ff;
    assign bus_error_ack = ack_ff;
    ////////////////////////////////////////////////////////////////////////
    // fault reported by bus error
    // lag lets the bench see a slow controller as well as a prompt one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ack_ff <= 1'b0;
            pend_ff <= 1'b0;
            cnt_ff <= 2'h0;
        end else begin
            ack_ff <= 1'b0;
            if (pend_ff && cnt_ff == 2'h0) begin
                ack_ff <= 1'b1;
                pend_ff <= 1'b0;
            end else if (pend_ff) begin
                cnt_ff <= cnt_ff - 2'h1;
            end
            if (fault) begin
                pend_ff <= 1'b1;
                cnt_ff <= lag;
            end
        end
    end
endmodule // mcc_mem_ctrl_model

// file: tb_machine_check_checkstop_unit.sv
/*
  tb_machine_check_checkstop_unit: self-checking bench for mcc_unit.
  assumes: mcc_cfg.svh offsets, axi4-lite master here, fault model beside.
*/
`include "mcc_cfg.svh"

module tb_machine_check_checkstop_unit;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid;
    logic awready, wready, arready, bus_error_ack, hrp, cs, lost, fault, iet;
    logic insn_exc_take, fetch_redirect, insn_suspend, latch_freeze, checkstop_out;
    logic data_bus_oe, mc_imprecise;
    logic [1:0] bresp, rresp, lag;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, insn_addr, fetch_addr;
    int error_cnt, checked;
    mcc_unit mcc_unit_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .bus_error_ack(bus_error_ack), .hard_reset_pending(hrp),
        .insn_addr(insn_addr), .insn_exc_req(1'b1), .context_sync(cs),
        .lost_pending_exc(lost), .data_bus_req(1'b1), .insn_exc_take(insn_exc_take),
        .fetch_redirect(fetch_redirect), .fetch_addr(fetch_addr),
        .insn_suspend(insn_suspend), .latch_freeze(latch_freeze),
        .checkstop_out(checkstop_out), .data_bus_oe(data_bus_oe),
        .mc_imprecise(mc_imprecise));
    mcc_mem_ctrl_model mcc_mem_ctrl_model_i (.aclk(aclk), .aresetn(aresetn),
        .fault(fault), .lag(lag), .bus_error_ack(bus_error_ack));
    ////////////////////////////////////////////////////////////////////////
    // clock, 50 MHz
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    // value seen against value expected
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task end_of_test;
        if (error_cnt == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // axi4-lite master: hold each channel until its ready is sampled high
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do @(posedge aclk); while (awready !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        bready <= 1'b1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(32'(bresp), 32'(er));
    endtask
    task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata, ed);
        chk(32'(rresp), 32'(er));
    endtask
    // fault through the model; iet holds insn_exc_take in the event cycle
    task berr(input logic [1:0] l);
        @(posedge aclk);
        lag <= l;
        fault <= 1'b1;
        @(posedge aclk);
        fault <= 1'b0;
        do @(negedge aclk); while (bus_error_ack !== 1'b1);
        iet = insn_exc_take;
        @(posedge aclk);
        #1;
    endtask
    task do_reset;
        aresetn <= 1'b0;
        hrp <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // reset values, unmapped and read-only places
    task t_regs;
        rd(`MCC_OFS_MSW, `MCC_MSW_RST, `MCC_RESP_OKAY);
        rd(`MCC_OFS_CTRL, `MCC_CTRL_RST, `MCC_RESP_OKAY);
        rd(8'h20, 32'h0, `MCC_RESP_SLVERR);
        wr(8'h20, 32'h5, `MCC_RESP_SLVERR);
        wr(`MCC_OFS_SRA, 32'h5, `MCC_RESP_OKAY);
        rd(`MCC_OFS_SRA, 32'h0, `MCC_RESP_OKAY);
        rd(`MCC_OFS_HW0, `MCC_HW0_RST, `MCC_RESP_OKAY);
        wr(`MCC_OFS_HW0, 32'hFFFFFFFF, `MCC_RESP_OKAY);
        rd(`MCC_OFS_HW0, `MCC_HW0_MASK, `MCC_RESP_OKAY);
    endtask
    // taken check, then a second one before enable is set again
    task t_take;
        do_reset();
        cs <= 1'b1;
        insn_addr <= 32'h00001234;
        wr(`MCC_OFS_MSW, 32'h00011002, `MCC_RESP_OKAY);
        chk(32'({insn_exc_take, data_bus_oe}), 32'h3);
        berr(2'h0);
        chk(32'(iet), 32'h0);
        chk(32'(fetch_redirect), 32'h1);
        chk(fetch_addr, `MCC_MC_VECTOR);
        chk(32'(data_bus_oe), 32'h0);
        @(posedge aclk);
        #1;
        chk(32'(fetch_redirect), 32'h0);
        chk(32'(data_bus_oe), 32'h1);
        rd(`MCC_OFS_STAT, 32'h2, `MCC_RESP_OKAY);
        wr(`MCC_OFS_STAT, 32'h6, `MCC_RESP_OKAY);
        rd(`MCC_OFS_STAT, 32'h0, `MCC_RESP_OKAY);
        rd(`MCC_OFS_SRA, 32'h00001234, `MCC_RESP_OKAY);
        rd(`MCC_OFS_SMS, 32'h00011002, `MCC_RESP_OKAY);
        rd(`MCC_OFS_MSW, 32'h00010001, `MCC_RESP_OKAY);
        berr(2'h2);
        chk(32'({checkstop_out, latch_freeze, insn_suspend}), 32'h7);
        chk(32'(fetch_redirect), 32'h0);
        wr(`MCC_OFS_MSW, 32'h00001000, `MCC_RESP_OKAY);
        rd(`MCC_OFS_MSW, 32'h00010001, `MCC_RESP_OKAY);
        chk(32'({checkstop_out, latch_freeze, insn_exc_take}), 32'h6);
    endtask
    // hard reset pending, then unrecoverable cases with both vector bases
    task t_unrec;
        logic [31:0] m;
        do_reset();
        wr(`MCC_OFS_MSW, 32'h00001002, `MCC_RESP_OKAY);
        hrp <= 1'b1;
        berr(2'h0);
        chk(32'({fetch_redirect, checkstop_out}), 32'h0);
        hrp <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            m = 32'h00001002 | (32'(i) << 6);
            cs <= (i == 1);
            lost <= (i == 1);
            wr(`MCC_OFS_MSW, m, `MCC_RESP_OKAY);
            berr(2'h1);
            chk(fetch_addr, (i == 1 ? `MCC_VEC_HIGH : 32'h0) | `MCC_MC_VECTOR);
            rd(`MCC_OFS_SMS, m & ~32'h2, `MCC_RESP_OKAY);
        end
    endtask
    // single-bus variant over all four gate settings, enable clear
    task t_variant;
        logic [31:0] g;
        do_reset();
        wr(`MCC_OFS_CTRL, 32'h1, `MCC_RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            g = {i[0], 15'h0, i[1], 15'h0};
            wr(`MCC_OFS_HW0, g, `MCC_RESP_OKAY);
            berr(2'h0);
            chk(32'(checkstop_out), 32'(i == 3));
            chk(32'(fetch_redirect), 32'(i != 3));
        end
        chk(32'(mc_imprecise), 32'h1);
        rd(`MCC_OFS_STAT, 32'h7 | (32'(mcc_pkg::mcc_st_frozen) << `MCC_STAT_STATE),
            `MCC_RESP_OKAY);
    endtask
    // two reports back to back: the second lands in the redirect cycle
    task t_pair;
        do_reset();
        wr(`MCC_OFS_MSW, 32'h00001000, `MCC_RESP_OKAY);
        @(posedge aclk);
        lag <= 2'h0;
        fault <= 1'b1;
        repeat (2) @(posedge aclk);
        fault <= 1'b0;
        repeat (3) @(posedge aclk);
        #1;
        chk(32'({checkstop_out, fetch_redirect}), 32'h2);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // main sequence and watchdog; a run takes well under 2000 cycles
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, hrp, cs, lost} = '0;
        {fault, lag, awaddr, araddr, wdata, insn_addr} = '0;
        error_cnt = 0;
        checked = 0;
        do_reset();
        t_regs();
        t_take();
        t_pair();
        t_unrec();
        t_variant();
        end_of_test();
    end
    initial begin
        repeat (6000) @(posedge aclk);
        error_cnt++;
        end_of_test();
    end
endmodule // tb_machine_check_checkstop_unit
